// ---- rtl/fns_pkg.sv ----
package fns_pkg;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS  = 4;
	localparam int DATA_BITS  = 12;
	localparam int CNT_BITS   = 5;
	localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h10;

	localparam logic [ADDR_BITS-1:0] ADDR_DIVIDER  = 4'h0;
	localparam logic [ADDR_BITS-1:0] ADDR_DVD_MSB  = 4'h1;
	localparam logic [ADDR_BITS-1:0] ADDR_DVD_LSB  = 4'h2;
	localparam logic [ADDR_BITS-1:0] ADDR_MOD_DATA = 4'h3;
	localparam logic [ADDR_BITS-1:0] ADDR_REF_DIV  = 4'h4;
	localparam logic [ADDR_BITS-1:0] ADDR_MODE     = 4'h5;
	localparam logic [ADDR_BITS-1:0] ADDR_CP_GAIN  = 4'h6;

	localparam int NREG_BITS = 9;
	localparam int MSB_BITS  = 10;
	localparam int LSB_BITS  = 8;
	localparam int ACC_BITS  = 18;
	localparam int REF_BITS  = 5;
	localparam int GAIN_BITS = 3;
	localparam int VCNT_BITS = 10;
	localparam int CARRY18   = 18;
	localparam int CARRY10   = 10;

	localparam logic [VCNT_BITS-1:0] N_OFFSET   = 10'h020;
	localparam logic [NREG_BITS-1:0] NREG_F_MIN = 9'h006;
	localparam logic [NREG_BITS-1:0] NREG_F_MAX = 9'h1f9;
	localparam logic [ACC_BITS-1:0]  MASK18     = 18'h3ffff;
	localparam logic [ACC_BITS-1:0]  MASK10     = 18'h003ff;

	localparam logic [2:0] MUX_XTAL   = 3'h0;
	localparam logic [2:0] MUX_REF    = 3'h1;
	localparam logic [2:0] MUX_VCO    = 3'h2;
	localparam logic [2:0] MUX_SERIAL = 3'h3;
	localparam logic [2:0] MUX_TEST   = 3'h4;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} fns_frame_t;

	// mode register layout, low byte of its data field
	typedef struct packed {
		logic [DATA_BITS-9:0] spare;
		logic                 pd_all;
		logic                 pd_ref;
		logic                 frac_mode;
		logic                 res18;
		logic                 mux_tri;
		logic [2:0]           mux_sel;
	} fns_mode_t;

	localparam fns_mode_t MODE_RESET = '0;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_SHIFT = 2'b01,
		RX_FULL  = 2'b11
	} fns_rx_state_t;
endpackage

// ---- rtl/fns_serial_rx.sv ----
module fns_serial_rx (
	input  wire logic        mclk_i,      // system clock
	input  wire logic        resetn_i,    // async reset, active low
	input  wire logic        sclk_rise_i, // synchronised serial clock rising edge
	input  wire logic        cs_low_i,    // synchronised select, high while selected
	input  wire logic        cs_rise_i,   // select just returned high
	input  wire logic        data_i,      // synchronised serial data
	output logic             valid_o,     // one-cycle frame strobe
	output fns_pkg::fns_frame_t frame_o,  // last 16 bits shifted
	output logic             bit_o        // most recently sampled bit
);
	fns_pkg::fns_rx_state_t      state_reg, state_next;
	logic [fns_pkg::FRAME_BITS-1:0] sr_reg;
	logic [fns_pkg::CNT_BITS-1:0]   cnt_reg;
	logic                        take;
	logic [fns_pkg::CNT_BITS-1:0]   cnt_next;

	assign take     = cs_low_i & sclk_rise_i;
	assign cnt_next = (cnt_reg == fns_pkg::FRAME_LEN) ? cnt_reg : cnt_reg + 5'h01;

	always_comb begin
		case (state_reg)
			fns_pkg::RX_IDLE:  state_next = cs_low_i ? fns_pkg::RX_SHIFT : fns_pkg::RX_IDLE;
			fns_pkg::RX_SHIFT: state_next = !cs_low_i ? fns_pkg::RX_IDLE :
				(take && cnt_next == fns_pkg::FRAME_LEN) ? fns_pkg::RX_FULL : fns_pkg::RX_SHIFT;
			fns_pkg::RX_FULL:  state_next = cs_low_i ? fns_pkg::RX_FULL : fns_pkg::RX_IDLE;
			default:           state_next = fns_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= fns_pkg::RX_IDLE;
			sr_reg    <= '0;
			cnt_reg   <= '0;
			valid_o   <= 1'b0;
			frame_o   <= '0;
			bit_o     <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!cs_low_i) begin
				cnt_reg <= '0;
			end else if (take) begin
				sr_reg  <= {sr_reg[fns_pkg::FRAME_BITS-2:0], data_i};
				cnt_reg <= cnt_next;
				bit_o   <= data_i;
			end
			// short frames never raise valid
			valid_o <= cs_rise_i && state_reg == fns_pkg::RX_FULL;
			if (cs_rise_i && state_reg == fns_pkg::RX_FULL) begin
				frame_o <= sr_reg;
			end
		end
	end
endmodule

// ---- rtl/fns_synth_ctrl.sv ----
module fns_synth_ctrl (
	input  wire logic                          mclk_i,             // 50 MHz system clock
	input  wire logic                          resetn_i,           // async reset, active low
	input  wire logic                          sclk_i,             // serial clock pin
	input  wire logic                          sdata_i,            // serial data pin
	input  wire logic                          cs_n_i,             // chip select pin, active low
	input  wire logic                          mod_sdata_i,        // modulation serial input
	input  wire logic                          xtal_i,             // crystal oscillator level
	input  wire logic                          vco_i,              // prescaled vco level
	input  wire logic                          pd_locked_i,        // phase detector lock status
	output logic                               lock_indicator_o,   // low while out of lock
	output logic                               ref_div_o,          // divided reference pulse
	output logic                               vco_div_o,          // divided vco pulse
	output logic [fns_pkg::GAIN_BITS-1:0]      cp_gain_o,          // charge pump gain code
	output logic                               pd_all_o,           // full power-down
	output logic                               pd_ref_o,           // reference path power-down
	output logic                               mux_out_o,          // observation mux output
	output logic                               mux_out_oe_o        // mux output enable
);
	localparam int NSYNC = 7;

	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic [NSYNC-1:0] prev_reg;
	logic             s_sclk, s_data, s_cs_n, s_mod, s_xtal, s_vco, s_lock;
	logic             sclk_rise, sclk_fall, cs_low, cs_rise, xtal_rise, vco_rise;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_reg <= 7'h01;
			sync2_reg <= 7'h01;
			prev_reg  <= 7'h01;
		end else begin
			sync1_reg <= {pd_locked_i, vco_i, xtal_i, mod_sdata_i, sdata_i, sclk_i, cs_n_i};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign {s_lock, s_vco, s_xtal, s_mod, s_data, s_sclk, s_cs_n} = sync2_reg;
	assign sclk_rise = s_sclk & ~prev_reg[1];
	assign sclk_fall = ~s_sclk & prev_reg[1];
	assign cs_low    = ~s_cs_n;
	assign cs_rise   = s_cs_n & ~prev_reg[0];
	assign xtal_rise = s_xtal & ~prev_reg[4];
	assign vco_rise  = s_vco & ~prev_reg[5];

	// both receivers share the serial clock and select
	logic                main_valid, mod_valid, main_bit;
	fns_pkg::fns_frame_t main_frame, mod_frame;

	fns_serial_rx u_main_rx (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.sclk_rise_i (sclk_rise),
		.cs_low_i    (cs_low),
		.cs_rise_i   (cs_rise),
		.data_i      (s_data),
		.valid_o     (main_valid),
		.frame_o     (main_frame),
		.bit_o       (main_bit)
	);

	fns_serial_rx u_mod_rx (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.sclk_rise_i (sclk_rise),
		.cs_low_i    (cs_low),
		.cs_rise_i   (cs_rise),
		.data_i      (s_mod),
		.valid_o     (mod_valid),
		.frame_o     (mod_frame),
		.bit_o       ()
	);

	// register file
	logic [fns_pkg::NREG_BITS-1:0] nreg_reg, nreg_act_reg;
	logic [fns_pkg::MSB_BITS-1:0]  msb_reg;
	logic [fns_pkg::LSB_BITS-1:0]  lsb_reg, lsb_act_reg;
	logic [fns_pkg::ACC_BITS-1:0]  dvd_act_reg;
	logic [fns_pkg::DATA_BITS-1:0] mod_reg;
	logic [fns_pkg::REF_BITS-1:0]  ref_ratio_reg;
	fns_pkg::fns_mode_t            mode_reg;
	logic [fns_pkg::GAIN_BITS-1:0] gain_reg;

	logic [fns_pkg::DATA_BITS-1:0] wdata;
	logic wr_div, wr_msb, wr_lsb, wr_mod, wr_ref, wr_mode, wr_gain, mod_wr;

	assign wdata   = main_frame.data;
	assign wr_div  = main_valid && main_frame.addr == fns_pkg::ADDR_DIVIDER;
	assign wr_msb  = main_valid && main_frame.addr == fns_pkg::ADDR_DVD_MSB;
	assign wr_lsb  = main_valid && main_frame.addr == fns_pkg::ADDR_DVD_LSB;
	assign wr_mod  = main_valid && main_frame.addr == fns_pkg::ADDR_MOD_DATA;
	assign wr_ref  = main_valid && main_frame.addr == fns_pkg::ADDR_REF_DIV;
	assign wr_mode = main_valid && main_frame.addr == fns_pkg::ADDR_MODE;
	assign wr_gain = main_valid && main_frame.addr == fns_pkg::ADDR_CP_GAIN;
	// the modulation stream may only reach the modulation data register
	assign mod_wr  = mod_valid && mod_frame.addr == fns_pkg::ADDR_MOD_DATA;

	// new dividend: the msb write over the staged lsb in 18-bit mode, the msb write alone in 10-bit mode
	logic [fns_pkg::ACC_BITS-1:0] dvd_new;
	assign dvd_new = mode_reg.res18 ?
		{wdata[fns_pkg::MSB_BITS-1:0], lsb_reg} :
		{8'h00, wdata[fns_pkg::MSB_BITS-1:0]};

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nreg_reg      <= '0;
			nreg_act_reg  <= '0;
			msb_reg       <= '0;
			lsb_reg       <= '0;
			lsb_act_reg   <= '0;
			dvd_act_reg   <= '0;
			mod_reg       <= '0;
			ref_ratio_reg <= '0;
			mode_reg      <= fns_pkg::MODE_RESET;
			gain_reg      <= '0;
		end else begin
			if (wr_div) begin
				nreg_reg <= wdata[fns_pkg::NREG_BITS-1:0];
			end
			// integer mode: divider applies at once; fractional waits for msb
			if (wr_div && !mode_reg.frac_mode) begin
				nreg_act_reg <= wdata[fns_pkg::NREG_BITS-1:0];
			end else if (wr_msb) begin
				nreg_act_reg <= nreg_reg;
			end
			if (wr_lsb) begin
				lsb_reg <= wdata[fns_pkg::LSB_BITS-1:0];
			end
			if (wr_msb) begin
				msb_reg     <= wdata[fns_pkg::MSB_BITS-1:0];
				lsb_act_reg <= lsb_reg;
				dvd_act_reg <= dvd_new;
			end
			if (wr_mod) begin
				mod_reg <= wdata;
			end else if (mod_wr) begin
				mod_reg <= mod_frame.data;
			end
			if (wr_ref) begin
				ref_ratio_reg <= wdata[fns_pkg::REF_BITS-1:0];
			end
			if (wr_mode) begin
				mode_reg <= fns_pkg::fns_mode_t'(wdata);
			end
			if (wr_gain) begin
				gain_reg <= wdata[fns_pkg::GAIN_BITS-1:0];
			end
		end
	end

	// reference divider: ratio code k divides by k+1
	logic [fns_pkg::REF_BITS-1:0] ref_cnt_reg;
	logic                         ref_run, ref_tick;

	assign ref_run  = !mode_reg.pd_all && !mode_reg.pd_ref && xtal_rise;
	assign ref_tick = ref_run && ref_cnt_reg >= ref_ratio_reg;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_cnt_reg <= '0;
		end else if (ref_tick) begin
			ref_cnt_reg <= '0;
		end else if (ref_run) begin
			ref_cnt_reg <= ref_cnt_reg + 5'h01;
		end
	end

	// vco divider with first-order modulator; the carry stretches one cycle
	logic [fns_pkg::NREG_BITS-1:0] nreg_eff;
	logic [fns_pkg::ACC_BITS-1:0]  acc_reg, frac_word, acc_mask;
	logic [fns_pkg::ACC_BITS:0]    acc_sum;
	logic                          carry, carry_reg;
	logic [fns_pkg::VCNT_BITS-1:0] vcnt_reg, n_eff;
	logic                          vco_run, vco_tick;

	// clamp keeps the fractional ratio inside 38..537
	assign nreg_eff = !mode_reg.frac_mode ? nreg_act_reg :
		(nreg_act_reg < fns_pkg::NREG_F_MIN) ? fns_pkg::NREG_F_MIN :
		(nreg_act_reg > fns_pkg::NREG_F_MAX) ? fns_pkg::NREG_F_MAX : nreg_act_reg;
	assign acc_mask  = mode_reg.res18 ? fns_pkg::MASK18 : fns_pkg::MASK10;
	assign frac_word = (dvd_act_reg + {6'h00, mod_reg}) & acc_mask;
	assign acc_sum   = {1'b0, acc_reg} + {1'b0, frac_word};
	assign carry     = mode_reg.frac_mode &&
		(mode_reg.res18 ? acc_sum[fns_pkg::CARRY18] : acc_sum[fns_pkg::CARRY10]);
	assign n_eff     = fns_pkg::N_OFFSET + {1'b0, nreg_eff} + {9'h000, carry_reg};
	assign vco_run   = !mode_reg.pd_all && vco_rise;
	assign vco_tick  = vco_run && vcnt_reg >= n_eff - 10'h001;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vcnt_reg  <= '0;
			acc_reg   <= '0;
			carry_reg <= 1'b0;
		end else begin
			if (vco_tick) begin
				vcnt_reg  <= '0;
				acc_reg   <= mode_reg.frac_mode ? (acc_sum[fns_pkg::ACC_BITS-1:0] & acc_mask) : '0;
				carry_reg <= carry;
			end else if (vco_run) begin
				vcnt_reg <= vcnt_reg + 10'h001;
			end
		end
	end

	// observation mux; echo bit changes on falling serial clock only
	logic echo_reg, mux_sel_bit;

	always_comb begin
		case (mode_reg.mux_sel)
			fns_pkg::MUX_XTAL:   mux_sel_bit = s_xtal;
			fns_pkg::MUX_REF:    mux_sel_bit = ref_div_o;
			fns_pkg::MUX_VCO:    mux_sel_bit = vco_div_o;
			fns_pkg::MUX_SERIAL: mux_sel_bit = echo_reg;
			fns_pkg::MUX_TEST:   mux_sel_bit = s_lock;
			default:             mux_sel_bit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			echo_reg         <= 1'b0;
			lock_indicator_o <= 1'b0;
			ref_div_o        <= 1'b0;
			vco_div_o        <= 1'b0;
			cp_gain_o        <= '0;
			pd_all_o         <= 1'b0;
			pd_ref_o         <= 1'b0;
			mux_out_o        <= 1'b0;
			mux_out_oe_o     <= 1'b0;
		end else begin
			if (sclk_fall && cs_low) begin
				echo_reg <= main_bit;
			end
			lock_indicator_o <= s_lock;
			ref_div_o        <= ref_tick;
			vco_div_o        <= vco_tick;
			cp_gain_o        <= gain_reg;
			pd_all_o         <= mode_reg.pd_all;
			pd_ref_o         <= mode_reg.pd_ref;
			mux_out_o        <= mode_reg.mux_tri ? 1'b0 : mux_sel_bit;
			mux_out_oe_o     <= !mode_reg.mux_tri;
		end
	end
endmodule

// ---- tb/fns_host_model.sv ----
module fns_host_model (
	input	wire logic	mclk_i,	// pacing clock
	output	logic	sclk_o,	// serial clock, still outside frames except during stray
	output	logic	sdata_o,	// serial data
	output	logic	cs_n_o,	// select, active low
	output	logic	mod_sdata_o	// modulation line, parked on an unmapped address
);
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		cs_n_o = 1'b1;
		mod_sdata_o = 1'b1;
	end
	task automatic pace(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// phases of six cycles keep the synchroniser inside its three-cycle minimum
	// the modulation line shares clock and select, so both frames go out together
	task automatic send_both(input logic [31:0] bits, input logic [31:0] mbits, input int n);
		cs_n_o = 1'b0;
		sdata_o = bits[n-1];
		mod_sdata_o = mbits[n-1];
		pace(6);
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b1;
			pace(6);
			sclk_o = 1'b0;
			sdata_o = (i > 0) ? bits[i-1] : ~bits[0];
			mod_sdata_o = (i > 0) ? mbits[i-1] : 1'b1;
			pace(6);
		end
		cs_n_o = 1'b1;
		pace(10);
	endtask
	task automatic send(input logic [31:0] bits, input int n);
		send_both(bits, 32'hffffffff, n);
	endtask
	task automatic stray(input int n);
		repeat (n) begin
			sclk_o = ~sclk_o;
			sdata_o = ~sdata_o;
			pace(4);
		end
		// park the clock low, or the next frame would lose its first rising edge
		sclk_o = 1'b0;
		pace(4);
	endtask
endmodule

// ---- tb/fns_synth_ctrl_asserts.sv ----
module fns_synth_ctrl_asserts (
	input	wire logic	mclk_i,	// system clock
	input	wire logic	resetn_i,	// async reset, active low
	input	wire logic	sclk_i,	// serial clock pin
	input	wire logic	sdata_i,	// serial data pin
	input	wire logic	cs_n_i,	// select pin, active low
	input	wire logic	mod_sdata_i,	// modulation serial input
	input	wire logic	xtal_i,	// crystal level
	input	wire logic	vco_i,	// vco level
	input	wire logic	pd_locked_i,	// lock status
	input	wire logic	lock_indicator_o,	// lock output
	input	wire logic	ref_div_o,	// reference pulse
	input	wire logic	vco_div_o,	// vco pulse
	input	wire logic [fns_pkg::GAIN_BITS-1:0]	cp_gain_o,	// gain code
	input	wire logic	pd_all_o,	// full power-down
	input	wire logic	pd_ref_o,	// reference power-down
	input	wire logic	mux_out_o,	// observation output
	input	wire logic	mux_out_oe_o	// observation enable
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	// five cycles cover the two sync stages and the output register
	a_lock_high: assert property (pd_locked_i [*5] |-> lock_indicator_o)
		else $error("lock indicator low while locked");
	a_lock_low: assert property (!pd_locked_i [*5] |-> !lock_indicator_o)
		else $error("lock indicator high while unlocked");
	// a write lands at most five cycles after select rises, so eight quiet cycles are settled
	a_sel_hold: assert property (!cs_n_i [*8] |-> $stable({cp_gain_o, pd_all_o, pd_ref_o, mux_out_oe_o}))
		else $error("settings changed inside a frame");
	a_desel_hold: assert property (cs_n_i [*8] |-> $stable({cp_gain_o, pd_all_o, pd_ref_o, mux_out_oe_o}))
		else $error("settings changed while deselected");
	a_tri_quiet: assert property (!mux_out_oe_o |-> !mux_out_o)
		else $error("mux output active while released");
	a_pd_all_stop: assert property (pd_all_o [*3] |-> !ref_div_o && !vco_div_o)
		else $error("divider pulse in full power-down");
	a_pd_ref_stop: assert property (pd_ref_o [*3] |-> !ref_div_o)
		else $error("reference pulse in reference power-down");
	a_ref_pulse: assert property (ref_div_o |=> !ref_div_o [*4])
		else $error("reference pulses too close");
	a_vco_pulse: assert property (vco_div_o |=> !vco_div_o [*8])
		else $error("vco pulses too close");
	c_gain_write: cover property ($changed(cp_gain_o));
	c_tri_state: cover property ($fell(mux_out_oe_o));
	c_lock_rise: cover property ($rose(lock_indicator_o));
endmodule
bind fns_synth_ctrl fns_synth_ctrl_asserts fns_synth_ctrl_asserts_inst (.mclk_i(mclk_i),
	.resetn_i(resetn_i), .sclk_i(sclk_i), .sdata_i(sdata_i), .cs_n_i(cs_n_i),
	.mod_sdata_i(mod_sdata_i), .xtal_i(xtal_i), .vco_i(vco_i), .pd_locked_i(pd_locked_i),
	.lock_indicator_o(lock_indicator_o), .ref_div_o(ref_div_o), .vco_div_o(vco_div_o),
	.cp_gain_o(cp_gain_o), .pd_all_o(pd_all_o), .pd_ref_o(pd_ref_o),
	.mux_out_o(mux_out_o), .mux_out_oe_o(mux_out_oe_o));

// ---- tb/tb_fns_synth_ctrl.sv ----
module tb_fns_synth_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic	mclk_i = 1'b0;
	logic	resetn_i = 1'b0;
	logic	xtal_i = 1'b0;
	logic	vco_i = 1'b0;
	logic	pd_locked_i = 1'b0;
	wire logic	sclk, sdata, cs_n, mod_sdata;
	logic	lock_o, ref_o, vco_o, pd_all_o, pd_ref_o, mux_o, oe_o, prev_bit;
	logic [fns_pkg::GAIN_BITS-1:0]	gain_o;
	logic	prev_ok = 1'b0;
	logic	echo_on = 1'b0;
	int	num_errors = 0;
	int	checked = 0;
	int	seed = 32'h6402;
	int	xc = 0;
	int	vc = 0;
	fns_host_model fns_host_model_inst (.mclk_i(mclk_i), .sclk_o(sclk), .sdata_o(sdata),
		.cs_n_o(cs_n), .mod_sdata_o(mod_sdata));
	fns_synth_ctrl fns_synth_ctrl_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .sclk_i(sclk),
		.sdata_i(sdata), .cs_n_i(cs_n), .mod_sdata_i(mod_sdata), .xtal_i(xtal_i),
		.vco_i(vco_i), .pd_locked_i(pd_locked_i), .lock_indicator_o(lock_o),
		.ref_div_o(ref_o), .vco_div_o(vco_o), .cp_gain_o(gain_o), .pd_all_o(pd_all_o),
		.pd_ref_o(pd_ref_o), .mux_out_o(mux_o), .mux_out_oe_o(oe_o));
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	// crystal period 10 cycles, vco period 8, both below a sixth of the clock
	always @(negedge mclk_i) begin
		xc <= (xc == 4) ? 0 : xc + 1;
		vc <= (vc == 3) ? 0 : vc + 1;
		if (xc == 4) xtal_i <= ~xtal_i;
		if (vc == 3) vco_i <= ~vco_i;
	end
	always @(posedge sclk) begin
		if (echo_on && prev_ok) cmp_v("echo", {15'h0, prev_bit}, {15'h0, mux_o});
		prev_bit = sdata;
		prev_ok = 1'b1;
	end
	always @(negedge cs_n) prev_ok = 1'b0;
	task automatic conclude();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp_v(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_n(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		fns_host_model_inst.send({16'h0, a, d}, 16);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// the first two intervals after a change may straddle old and new ratios, so they are skipped
	task automatic span(input logic use_vco, input int cnt, output int n);
		int t;
		n = 0;
		for (int k = 0; k < cnt + 2; k++) begin
			t = 0;
			do begin
				@(negedge mclk_i);
				t++;
			end while ((use_vco ? vco_o : ref_o) !== 1'b1 && t < 6000);
			if (t >= 6000) begin
				$display("Error divider pulse expected within 6000 seen none");
				num_errors++;
				conclude();
			end
			if (k >= 2) n += t;
		end
	endtask
	function automatic int ref_span(input int r);
		return (r + 1) * 10;
	endfunction
	function automatic int vco_span(input int nreg, input int frac);
		return ((32 + nreg) * 2 + frac) * 8;
	endfunction
	initial begin
		fns_pkg::fns_mode_t m;
		int n;
		int p;
		logic [11:0] d;
		cycles(2);
		resetn_i = 1'b1;
		cycles(5);
		cmp_v("reset", 16'h0001, {10'h0, gain_o, pd_all_o, pd_ref_o, oe_o});
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 12'h000 : (i == 1) ? 12'h007 : 12'($random(seed)) & 12'h007;
			wr(fns_pkg::ADDR_CP_GAIN, d);
			cmp_v("gain", {4'h0, d}, {13'h0, gain_o});
		end
		fns_host_model_inst.send({12'habc, 4'h6, 12'h005}, 20);
		cmp_v("gain long", 16'h0005, {13'h0, gain_o});
		fns_host_model_inst.send({20'h0, 12'h602}, 12);
		cmp_v("gain short", 16'h0005, {13'h0, gain_o});
		fns_host_model_inst.stray(9);
		cycles(10);
		cmp_v("gain stray", 16'h0005, {13'h0, gain_o});
		wr(4'h7, 12'h002);
		cmp_v("gain unmapped", 16'h0005, {13'h0, gain_o});
		$display("test frames done");
		m = fns_pkg::MODE_RESET;
		m.mux_sel = fns_pkg::MUX_TEST;
		wr(fns_pkg::ADDR_MODE, m);
		for (int i = 0; i < 2; i++) begin
			pd_locked_i = ~pd_locked_i;
			cycles(6);
			cmp_v("lock", {15'h0, pd_locked_i}, {15'h0, lock_o});
			cmp_v("mux lock", {15'h0, pd_locked_i}, {15'h0, mux_o});
		end
		// ref ratio code 1 pulses every 20 cycles; vco ratio 32 pulses every 256
		wr(fns_pkg::ADDR_REF_DIV, 12'h001);
		for (int s = 0; s < 3; s++) begin
			m.mux_sel = (s == 0) ? fns_pkg::MUX_XTAL :
				(s == 1) ? fns_pkg::MUX_REF : fns_pkg::MUX_VCO;
			wr(fns_pkg::ADDR_MODE, m);
			n = 0;
			for (int i = 0; i < ((s == 2) ? 512 : 40); i++) begin
				p = mux_o;
				cycles(1);
				if (mux_o !== p[0]) n++;
			end
			cmp_n("mux toggles", (s == 0) ? 8 : 4, n);
		end
		m.mux_tri = 1'b1;
		wr(fns_pkg::ADDR_MODE, m);
		cmp_v("tri", 16'h0000, {14'h0, mux_o, oe_o});
		m.mux_tri = 1'b0;
		m.mux_sel = fns_pkg::MUX_SERIAL;
		wr(fns_pkg::ADDR_MODE, m);
		echo_on = 1'b1;
		d = 12'($random(seed)) | 12'h5a2;
		wr(fns_pkg::ADDR_CP_GAIN, d);
		echo_on = 1'b0;
		cmp_v("gain echo", {13'h0, d[2:0]}, {13'h0, gain_o});
		$display("test mux done");
		for (int i = 0; i < 3; i++) begin
			p = (i == 0) ? 0 : (i == 1) ? 31 : ($random(seed) & 31);
			wr(fns_pkg::ADDR_REF_DIV, 12'(p));
			span(1'b0, 1, n);
			cmp_n("ref span", ref_span(p), n);
		end
		for (int i = 0; i < 2; i++) begin
			p = i * 511;
			wr(fns_pkg::ADDR_DIVIDER, 12'(p));
			span(1'b1, 2, n);
			cmp_n("vco integer", vco_span(p, 0), n);
		end
		m.frac_mode = 1'b1;
		wr(fns_pkg::ADDR_MODE, m);
		wr(fns_pkg::ADDR_DIVIDER, 12'h006);
		wr(fns_pkg::ADDR_DVD_MSB, 12'h000);
		span(1'b1, 2, n);
		cmp_n("vco frac low", vco_span(6, 0), n);
		wr(fns_pkg::ADDR_DIVIDER, 12'h014);
		wr(fns_pkg::ADDR_DVD_LSB, 12'h000);
		span(1'b1, 2, n);
		cmp_n("vco frac pending", vco_span(6, 0), n);
		wr(fns_pkg::ADDR_DVD_MSB, 12'h200);
		span(1'b1, 2, n);
		cmp_n("vco frac half", vco_span(20, 1), n);
		// modulation word 0x200 on top of dividend 0x200 wraps the 10-bit step to zero
		fns_host_model_inst.send_both({16'h0, 4'h7, 12'h000},
			{16'h0, fns_pkg::ADDR_MOD_DATA, 12'h200}, 16);
		span(1'b1, 2, n);
		cmp_n("vco mod stream", vco_span(20, 0), n);
		wr(fns_pkg::ADDR_MOD_DATA, 12'h000);
		span(1'b1, 2, n);
		cmp_n("vco mod clear", vco_span(20, 1), n);
		m.res18 = 1'b1;
		wr(fns_pkg::ADDR_MODE, m);
		wr(fns_pkg::ADDR_DVD_LSB, 12'h000);
		wr(fns_pkg::ADDR_DVD_MSB, 12'h200);
		span(1'b1, 2, n);
		cmp_n("vco frac 18 bit", vco_span(20, 1), n);
		$display("test dividers done");
		m.pd_ref = 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(fns_pkg::ADDR_MODE, m);
			n = 0;
			for (int k = 0; k < 600; k++) begin
				cycles(1);
				n += (i == 0) ? ref_o : (ref_o | vco_o);
			end
			cmp_v("power down", {14'h0, m.pd_all, 1'b1}, {14'h0, pd_all_o, pd_ref_o});
			cmp_n("pulses in power down", 0, n);
			m.pd_all = 1'b1;
		end
		$display("test power down done");
		conclude();
	end
endmodule
